/* common/twm_consts.svh */
// Offsets, field positions, reset values and timing counts of the two-wire master
`ifndef TWM_CONSTS_SVH
`define TWM_CONSTS_SVH

// Register byte offsets on the APB
`define TWM_OFF_CTRL 8'h00
`define TWM_OFF_STAT 8'h04
`define TWM_OFF_DATA 8'h08
`define TWM_OFF_IRQ_STAT 8'h0C
`define TWM_OFF_IRQ_MASK 8'h10

// Control register field positions
`define TWM_CTRL_FLAG 7
`define TWM_CTRL_START 5
`define TWM_CTRL_STOP 4

// Reset values
`define TWM_CTRL_RST 8'h00
`define TWM_DATA_RST 8'hFF
`define TWM_STAT_RST 8'hF8

// Status codes, prescaler bits zero
`define TWM_ST_START 8'h08
`define TWM_ST_RSTART 8'h10
`define TWM_ST_AW_ACK 8'h18
`define TWM_ST_AW_NACK 8'h20
`define TWM_ST_D_ACK 8'h28
`define TWM_ST_D_NACK 8'h30
`define TWM_ST_ARB 8'h38
`define TWM_ST_AR_ACK 8'h40
`define TWM_ST_AR_NACK 8'h48
`define TWM_ST_IDLE 8'hF8
`define TWM_ST_MASK 8'hF8

// Quarter bit time on the wire and its cycle count at 250 MHz
`define TWM_CLK_MHZ 250
`define TWM_QTR_NS 2500
`define TWM_QTR_CYCLES ((`TWM_QTR_NS * `TWM_CLK_MHZ + 999) / 1000)

`endif

/* common/twm_pkg.sv */
// Types shared by the two-wire master transmitter
package twm_pkg;

	// Sequencer states
	typedef enum logic [2:0] {
		TWM_IDLE = 3'b000,
		TWM_WAIT = 3'b001,
		TWM_START = 3'b010,
		TWM_SHIFT = 3'b011,
		TWM_HOLD = 3'b100,
		TWM_STOP = 3'b101
	} twm_state_e;

	// Control register layout, bit 7 down to bit 0
	typedef struct packed {
		logic flag;
		logic ack_en;
		logic start;
		logic stop;
		logic wc;
		logic en;
		logic unused;
		logic ie;
	} twm_ctrl_s;

	// Sticky interrupt events
	typedef struct packed {
		logic collision;
		logic arb_lost;
		logic done;
	} twm_irq_s;

endpackage

/* tb/test_twm_master.sv */
// Self-checking bench for the two-wire master transmitter
`timescale 1ns/10ps
`default_nettype none
`include "twm_consts.svh"
module test_twm_master;
	logic ref_clk, rstn, psel, penable, pwrite, ack_on, err, grab;
	logic [7:0] paddr, b, rx_byte;
	logic [31:0] pwdata, prdata, q;
	logic pready, pslverr, scl_o, scl_oe, sda_o, sda_oe, irq, s_oe;
	wire logic scl = !scl_oe;
	wire logic sda = !(sda_oe || s_oe);
	int n_fail = 0;
	int n_checks = 0;
	int seed, n, i;
	twm_master #(.QTR_CYCLES(4)) u_twm_master (.ref_clk(ref_clk),
		.rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe),
		.sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq));
	twm_slave_model u_twm_slave_model (.ref_clk(ref_clk), .scl(scl),
		.sda(sda), .ack_on(ack_on), .grab(grab), .sda_oe(s_oe),
		.rx_byte(rx_byte));
	// Clock of 4 ns
	always #2 ref_clk = !ref_clk;
	// Status code expected after an address or data byte
	function automatic logic [7:0] exp_code(input logic is_addr,
		input logic rd, input logic ack);
		if (is_addr && rd) return ack ? `TWM_ST_AR_ACK : `TWM_ST_AR_NACK;
		if (is_addr) return ack ? `TWM_ST_AW_ACK : `TWM_ST_AW_NACK;
		return ack ? `TWM_ST_D_ACK : `TWM_ST_D_NACK;
	endfunction
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	// One APB transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int k;
		k = 0;
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1 && k++ < 50);
		if (k >= 50) chk("pready", 1, 0);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wait_flag;
		n = 0;
		do apb(0, `TWM_OFF_CTRL, 0); while (q[7] !== 1'b1 && n++ < 300);
		chk("flag", 1, q[7]);
	endtask
	// Load a byte, release the flag, compare status and wire byte
	task automatic send(input logic [7:0] v, input logic ak,
		input logic is_addr);
		ack_on <= ak;
		apb(1, `TWM_OFF_DATA, {24'h0, v});
		apb(1, `TWM_OFF_CTRL, 32'h85);
		wait_flag();
		apb(0, `TWM_OFF_STAT, 0);
		chk("status", exp_code(is_addr, v[0], ak), q & `TWM_ST_MASK);
		chk("wire byte", v, rx_byte);
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// Hang guard
	initial begin
		#200000;
		n_fail++;
		finish_test();
	end
	// Main sequence
	initial begin
		seed = 70304;
		ref_clk = 0;
		rstn = 0;
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = 0;
		pwdata = 0;
		ack_on = 1;
		grab = 0;
		repeat (2) @(posedge ref_clk);
		rstn <= 1'b1;
		apb(0, `TWM_OFF_CTRL, 0);
		chk("ctrl reset", `TWM_CTRL_RST, q);
		apb(0, `TWM_OFF_STAT, 0);
		chk("stat reset", `TWM_STAT_RST, q);
		apb(0, 8'h1C, 0);
		chk("unmapped", 1, err);
		apb(1, `TWM_OFF_DATA, 32'h5A);
		apb(0, `TWM_OFF_DATA, 0);
		chk("data kept", `TWM_DATA_RST, q);
		apb(0, `TWM_OFF_CTRL, 0);
		chk("collision", 1, q[3]);
		apb(1, `TWM_OFF_IRQ_MASK, 32'h1);
		apb(1, `TWM_OFF_CTRL, 32'hA5);
		wait_flag();
		apb(0, `TWM_OFF_STAT, 0);
		chk("start code", `TWM_ST_START, q);
		chk("irq", 1, irq);
		repeat (40) @(posedge ref_clk);
		chk("scl held", 1, scl_oe);
		b = $random(seed);
		send({b[7:1], 1'b0}, 1, 1);
		for (i = 0; i < 5; i++) begin
			b = $random(seed);
			send(b, b[3], 0);
		end
		apb(1, `TWM_OFF_CTRL, 32'hA5);
		wait_flag();
		apb(0, `TWM_OFF_STAT, 0);
		chk("rstart code", `TWM_ST_RSTART, q);
		send({b[7:1], 1'b1}, 1, 1);
		apb(1, `TWM_OFF_CTRL, 32'h95);
		n = 0;
		do apb(0, `TWM_OFF_CTRL, 0); while (q[4] !== 1'b0 && n++ < 100);
		chk("stop bit", 0, q[4]);
		repeat (20) @(posedge ref_clk);
		chk("bus free", 2'b00, {scl_oe, sda_oe});
		chk("open drain data", 2'b00, {scl_o, sda_o});
		apb(1, `TWM_OFF_CTRL, 32'hA5);
		wait_flag();
		send(8'hA4, 0, 1);
		apb(1, `TWM_OFF_CTRL, 32'hB5);
		wait_flag();
		chk("stop cleared", 0, q[4]);
		apb(0, `TWM_OFF_STAT, 0);
		chk("restart code", `TWM_ST_START, q);
		// Rival pulls sda low in the next frame: arbitration is lost
		grab <= 1'b1;
		apb(1, `TWM_OFF_CTRL, 32'hA5);
		wait_flag();
		apb(0, `TWM_OFF_STAT, 0);
		chk("rstart code", `TWM_ST_RSTART, q);
		apb(1, `TWM_OFF_DATA, 32'hC2);
		apb(1, `TWM_OFF_CTRL, 32'h85);
		wait_flag();
		apb(0, `TWM_OFF_STAT, 0);
		chk("arb code", `TWM_ST_ARB, q);
		chk("bus released", 2'b00, {scl_oe, sda_oe});
		apb(1, `TWM_OFF_CTRL, 32'hA5);
		repeat (40) @(posedge ref_clk);
		apb(0, `TWM_OFF_CTRL, 0);
		chk("start waits", 0, q[7]);
		grab <= 1'b0;
		wait_flag();
		apb(0, `TWM_OFF_STAT, 0);
		chk("free start code", `TWM_ST_START, q);
		apb(0, `TWM_OFF_IRQ_STAT, 0);
		chk("irq events", 32'h7, q);
		apb(1, `TWM_OFF_CTRL, 32'h04);
		repeat (2) @(posedge ref_clk);
		chk("irq masked in", 1, irq);
		apb(1, `TWM_OFF_IRQ_MASK, 32'h0);
		repeat (2) @(posedge ref_clk);
		chk("irq masked out", 0, irq);
		apb(1, `TWM_OFF_IRQ_STAT, 32'h7);
		apb(0, `TWM_OFF_IRQ_STAT, 0);
		chk("irq cleared", 0, q);
		finish_test();
	end
endmodule
`default_nettype wire

/* tb/twm_slave_model.sv */
// Behavioural slave receiver on the two-wire bus
`timescale 1ns/10ps
`default_nettype none
module twm_slave_model (
	input wire logic ref_clk,
	input wire logic scl,
	input wire logic sda,
	input wire logic ack_on,
	input wire logic grab,
	output logic sda_oe,
	output logic [7:0] rx_byte
);
	logic scl_q = 1'b1;
	logic sda_q = 1'b1;
	logic [7:0] sh = 8'h00;
	int bitn = 0;
	logic ack_oe = 1'b0;
	logic lost_oe = 1'b0;
	initial rx_byte = 8'h00;
	// A rival holding sda low wins arbitration; its release is a STOP
	assign sda_oe = ack_oe || lost_oe;
	// Watch the wires, shift in bits, pull sda low for the acknowledge
	always @(posedge ref_clk) begin
		scl_q <= scl;
		sda_q <= sda;
		if (!grab) begin
			lost_oe <= 1'b0;
		end
		if (scl && scl_q && sda_q && !sda) begin
			bitn <= 0; // START seen, frame restarts
		end else if (scl && !scl_q && bitn < 8) begin
			sh <= {sh[6:0], sda}; // MSB first
			bitn <= bitn + 1;
		end else if (!scl && scl_q) begin
			if (bitn == 8) begin
				ack_oe <= ack_on;
				rx_byte <= sh;
				bitn <= 9;
			end else if (bitn == 9) begin
				ack_oe <= 1'b0; // Release after the acknowledge bit
				bitn <= 0;
			end else if (grab) begin
				lost_oe <= 1'b1; // Rival drives low while scl is low
			end
		end
	end
endmodule
`default_nettype wire

/* verilog/twm_master.sv */
// Two-wire master transmitter with APB register access
`timescale 1ns/10ps
`default_nettype none
`include "twm_consts.svh"

// What this block does
// - Flag, start and enable written one: wait for free bus, send START.
// - After START, set the completion flag and report status 0x08.
// - Writing one to the completion flag clears it and resumes transfer.
// - Address direction bit selects transmitter or receiver mode.
// - After write address: flag set, 0x18 ack, 0x20 nack, 0x38 lost.
// - Data write while flag low is ignored and sets write collision.
// - In 0x18 to 0x30, plain flag clear sends data byte, samples ack.
// - After data byte: flag set, 0x28 on ack, 0x30 on nack.
// - Stop write sends STOP and hardware clears the stop request bit.
// - Start write during transfer sends repeated START, reports 0x10.
// - At 0x10 a read address is sent; later flag clears only set the flag again, no byte is received.
// - Start and stop both one: STOP, then new START, stop bit cleared.
// - At 0x38: start zero releases bus; start one restarts when free.
// - While the completion flag is set the bus transfer stays suspended.
module twm_master #(
	parameter int QTR_CYCLES = `TWM_QTR_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	output logic irq
);

	twm_pkg::twm_state_e state_reg;
	twm_pkg::twm_ctrl_s ctrl_reg;
	twm_pkg::twm_ctrl_s wd;
	twm_pkg::twm_irq_s irq_stat_reg;
	twm_pkg::twm_irq_s irq_mask_reg;
	twm_pkg::twm_irq_s irq_ev;
	logic flag_reg;
	logic [7:0] data_reg;
	logic [7:0] code_reg;
	logic [7:0] shift_reg;
	logic [3:0] bit_reg;
	logic [1:0] q_reg;
	logic [15:0] div_reg;
	logic qtick_reg;
	logic scl_s1_reg, scl_s2_reg, sda_s1_reg, sda_s2_reg, sda_s3_reg;
	logic busy_reg;
	logic rep_reg, restart_reg, is_addr_reg, ack_reg, rx_mode_reg;
	logic set_flag_reg, stop_done_reg, lost_reg;
	logic scl_oe_reg, sda_oe_reg, irq_reg, pready_reg, pslverr_reg;
	logic [31:0] prdata_reg;
	logic acc, wr_ctrl, wr_data, go, mapped;

	// Bus access handshake and decode
	assign acc = psel && penable && pready_reg;
	assign wd = twm_pkg::twm_ctrl_s'(pwdata[7:0]);
	assign wr_ctrl = acc && pwrite && paddr == `TWM_OFF_CTRL;
	assign wr_data = acc && pwrite && paddr == `TWM_OFF_DATA;
	assign go = wr_ctrl && wd.flag && wd.en;
	assign mapped = paddr == `TWM_OFF_CTRL || paddr == `TWM_OFF_STAT ||
		paddr == `TWM_OFF_DATA || paddr == `TWM_OFF_IRQ_STAT ||
		paddr == `TWM_OFF_IRQ_MASK;
	assign irq_ev = '{collision: wr_data && !flag_reg, arb_lost: lost_reg,
		done: set_flag_reg};

	// APB answer one cycle into the access phase, read data registered
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h0000_0000;
		end else begin
			pready_reg <= psel && penable && !pready_reg;
			pslverr_reg <= psel && penable && !pready_reg && !mapped;
			unique case (paddr)
				`TWM_OFF_CTRL: prdata_reg <= {24'h00_0000, flag_reg,
					ctrl_reg.ack_en, ctrl_reg.start, ctrl_reg.stop,
					ctrl_reg.wc, ctrl_reg.en, 1'b0, ctrl_reg.ie};
				`TWM_OFF_STAT: prdata_reg <= {24'h00_0000,
					code_reg & `TWM_ST_MASK};
				`TWM_OFF_DATA: prdata_reg <= {24'h00_0000, data_reg};
				`TWM_OFF_IRQ_STAT: prdata_reg <= {29'h0000_0000, irq_stat_reg};
				`TWM_OFF_IRQ_MASK: prdata_reg <= {29'h0000_0000, irq_mask_reg};
				default: prdata_reg <= 32'h0000_0000;
			endcase
		end
	end

	// Completion flag: hardware set wins over software clear
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			flag_reg <= 1'b0;
		end else if (set_flag_reg) begin
			flag_reg <= 1'b1;
		end else if (wr_ctrl && wd.flag) begin
			flag_reg <= 1'b0;
		end
	end

	// Control bits; stop request cleared by hardware after STOP
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			ctrl_reg <= twm_pkg::twm_ctrl_s'(`TWM_CTRL_RST);
		end else begin
			if (wr_ctrl) begin
				ctrl_reg.ack_en <= wd.ack_en;
				ctrl_reg.start <= wd.start;
				ctrl_reg.en <= wd.en;
				ctrl_reg.ie <= wd.ie;
			end
			if (stop_done_reg) begin
				ctrl_reg.stop <= 1'b0;
			end else if (wr_ctrl) begin
				ctrl_reg.stop <= wd.stop;
			end
			if (wr_data && !flag_reg) begin
				ctrl_reg.wc <= 1'b1;
			end else if (wr_data) begin
				ctrl_reg.wc <= 1'b0;
			end
		end
	end

	// Data register, loaded only while the flag is high
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			data_reg <= `TWM_DATA_RST;
		end else if (wr_data && flag_reg) begin
			data_reg <= pwdata[7:0];
		end
	end

	// Sticky interrupt status, write one to clear, set wins
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			irq_stat_reg <= '0;
			irq_mask_reg <= '0;
		end else begin
			if (acc && pwrite && paddr == `TWM_OFF_IRQ_MASK) begin
				irq_mask_reg <= twm_pkg::twm_irq_s'(pwdata[2:0]);
			end
			if (acc && pwrite && paddr == `TWM_OFF_IRQ_STAT) begin
				irq_stat_reg <= (irq_stat_reg & ~pwdata[2:0]) | irq_ev;
			end else begin
				irq_stat_reg <= irq_stat_reg | irq_ev;
			end
		end
	end

	// Interrupt output level
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= |(irq_stat_reg & irq_mask_reg) ||
				(flag_reg && ctrl_reg.ie);
		end
	end

	// Line synchronisers and bus busy tracking
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			scl_s1_reg <= 1'b1;
			scl_s2_reg <= 1'b1;
			sda_s1_reg <= 1'b1;
			sda_s2_reg <= 1'b1;
			sda_s3_reg <= 1'b1;
			busy_reg <= 1'b0;
		end else begin
			scl_s1_reg <= scl_i;
			scl_s2_reg <= scl_s1_reg;
			sda_s1_reg <= sda_i;
			sda_s2_reg <= sda_s1_reg;
			sda_s3_reg <= sda_s2_reg;
			if (scl_s2_reg && sda_s3_reg && !sda_s2_reg) begin
				busy_reg <= 1'b1;
			end else if (scl_s2_reg && !sda_s3_reg && sda_s2_reg) begin
				busy_reg <= 1'b0;
			end
		end
	end

	// Quarter bit time divider
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			div_reg <= 16'h0000;
			qtick_reg <= 1'b0;
		end else begin
			qtick_reg <= div_reg == 16'(QTR_CYCLES - 1);
			div_reg <= div_reg == 16'(QTR_CYCLES - 1) ? 16'h0000 :
				div_reg + 16'h0001;
		end
	end

	// Transfer sequencer
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			state_reg <= twm_pkg::TWM_IDLE;
			code_reg <= `TWM_STAT_RST;
			shift_reg <= 8'h00;
			bit_reg <= 4'h0;
			q_reg <= 2'b00;
			rep_reg <= 1'b0;
			restart_reg <= 1'b0;
			is_addr_reg <= 1'b0;
			ack_reg <= 1'b0;
			rx_mode_reg <= 1'b0;
			set_flag_reg <= 1'b0;
			stop_done_reg <= 1'b0;
			lost_reg <= 1'b0;
			scl_oe_reg <= 1'b0;
			sda_oe_reg <= 1'b0;
		end else begin
			set_flag_reg <= 1'b0;
			stop_done_reg <= 1'b0;
			lost_reg <= 1'b0;
			if (!ctrl_reg.en && !go) begin // A go write enables at once
				state_reg <= twm_pkg::TWM_IDLE;
				scl_oe_reg <= 1'b0;
				sda_oe_reg <= 1'b0;
			end else begin
				unique case (state_reg)
					twm_pkg::TWM_IDLE: begin
						if (go && wd.start) begin
							state_reg <= twm_pkg::TWM_WAIT;
							rep_reg <= 1'b0;
						end
					end
					twm_pkg::TWM_WAIT: begin
						if (qtick_reg && !busy_reg) begin
							state_reg <= twm_pkg::TWM_START;
							q_reg <= 2'b00;
						end
					end
					twm_pkg::TWM_START: begin
						if (qtick_reg) begin
							q_reg <= q_reg + 2'b01;
							unique case (q_reg)
								2'b00: sda_oe_reg <= 1'b0;
								2'b01: scl_oe_reg <= 1'b0;
								2'b10: sda_oe_reg <= 1'b1;
								2'b11: begin
									scl_oe_reg <= 1'b1;
									state_reg <= twm_pkg::TWM_HOLD;
									code_reg <= rep_reg ? `TWM_ST_RSTART :
										`TWM_ST_START;
									rx_mode_reg <= 1'b0;
									set_flag_reg <= 1'b1;
								end
							endcase
						end
					end
					twm_pkg::TWM_SHIFT: begin
						if (qtick_reg) begin
							q_reg <= q_reg + 2'b01;
							unique case (q_reg)
								2'b00: sda_oe_reg <= bit_reg != 4'h8 && !shift_reg[7];
								2'b01: scl_oe_reg <= 1'b0;
								2'b10: begin
									if (bit_reg == 4'h8) begin
										ack_reg <= !sda_s2_reg;
									end else if (!sda_oe_reg && !sda_s2_reg) begin
										state_reg <= twm_pkg::TWM_HOLD;
										code_reg <= `TWM_ST_ARB;
										sda_oe_reg <= 1'b0;
										set_flag_reg <= 1'b1;
										lost_reg <= 1'b1;
									end
								end
								2'b11: begin
									scl_oe_reg <= 1'b1;
									shift_reg <= {shift_reg[6:0], 1'b0};
									bit_reg <= bit_reg + 4'h1;
									if (bit_reg == 4'h8) begin
										state_reg <= twm_pkg::TWM_HOLD;
										set_flag_reg <= 1'b1;
										if (!is_addr_reg) begin
											code_reg <= ack_reg ? `TWM_ST_D_ACK :
												`TWM_ST_D_NACK;
										end else if (rx_mode_reg) begin
											code_reg <= ack_reg ? `TWM_ST_AR_ACK :
												`TWM_ST_AR_NACK;
										end else begin
											code_reg <= ack_reg ? `TWM_ST_AW_ACK :
												`TWM_ST_AW_NACK;
										end
									end
								end
							endcase
						end
					end
					twm_pkg::TWM_HOLD: begin
						if (go && flag_reg) begin
							q_reg <= 2'b00;
							if (wd.stop) begin
								state_reg <= twm_pkg::TWM_STOP;
								restart_reg <= wd.start;
							end else if (code_reg == `TWM_ST_ARB) begin
								state_reg <= wd.start ? twm_pkg::TWM_WAIT :
									twm_pkg::TWM_IDLE;
								rep_reg <= 1'b0;
								scl_oe_reg <= 1'b0;
								sda_oe_reg <= 1'b0;
							end else if (wd.start) begin
								state_reg <= twm_pkg::TWM_START;
								rep_reg <= 1'b1;
							end else if (rx_mode_reg) begin
								set_flag_reg <= 1'b1;
							end else begin
								state_reg <= twm_pkg::TWM_SHIFT;
								shift_reg <= data_reg;
								bit_reg <= 4'h0;
								is_addr_reg <= code_reg == `TWM_ST_START ||
									code_reg == `TWM_ST_RSTART;
								if (code_reg == `TWM_ST_START ||
									code_reg == `TWM_ST_RSTART) begin
									rx_mode_reg <= data_reg[0];
								end
							end
						end
					end
					twm_pkg::TWM_STOP: begin
						if (qtick_reg) begin
							q_reg <= q_reg + 2'b01;
							unique case (q_reg)
								2'b00: sda_oe_reg <= 1'b1;
								2'b01: scl_oe_reg <= 1'b0;
								2'b10: sda_oe_reg <= 1'b0;
								2'b11: begin
									stop_done_reg <= 1'b1;
									code_reg <= `TWM_ST_IDLE;
									rx_mode_reg <= 1'b0;
									rep_reg <= 1'b0;
									state_reg <= restart_reg ? twm_pkg::TWM_WAIT :
										twm_pkg::TWM_IDLE;
								end
							endcase
						end
					end
					default: state_reg <= twm_pkg::TWM_IDLE;
				endcase
			end
		end
	end

	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign prdata = prdata_reg;
	assign scl_o = 1'b0;
	assign sda_o = 1'b0;
	assign scl_oe = scl_oe_reg;
	assign sda_oe = sda_oe_reg;
	assign irq = irq_reg;

	// Checks on the sequencer and register behaviour
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	sequence s_go_start;
		state_reg == twm_pkg::TWM_IDLE && go && wd.start;
	endsequence
	sequence s_start_end;
		state_reg == twm_pkg::TWM_START && qtick_reg && q_reg == 2'b11;
	endsequence
	sequence s_byte_end;
		state_reg == twm_pkg::TWM_SHIFT && qtick_reg && q_reg == 2'b11 &&
			bit_reg == 4'h8;
	endsequence

	a_go_waits:
	assert property (s_go_start |=> state_reg == twm_pkg::TWM_WAIT)
		else $error("start request did not wait for free bus");
	a_start_code:
	assert property (s_start_end ##0 !rep_reg |=> ##1 flag_reg &&
		code_reg == `TWM_ST_START)
		else $error("start did not report 0x08");
	a_flag_clear:
	assert property (wr_ctrl && wd.flag && !set_flag_reg |=> !flag_reg)
		else $error("completion flag not cleared");
	a_collision:
	assert property (wr_data && !flag_reg |=> ctrl_reg.wc && $stable(data_reg))
		else $error("collision write not ignored");
	a_data_code:
	assert property (s_byte_end ##0 !is_addr_reg |=>
		code_reg == (ack_reg ? `TWM_ST_D_ACK : `TWM_ST_D_NACK) ##1 flag_reg)
		else $error("wrong data status code");
	a_addr_code:
	assert property (s_byte_end ##0 is_addr_reg && !rx_mode_reg |=>
		code_reg == (ack_reg ? `TWM_ST_AW_ACK : `TWM_ST_AW_NACK))
		else $error("wrong address status code");
	a_stop_clear:
	assert property (state_reg == twm_pkg::TWM_STOP && qtick_reg &&
		q_reg == 2'b11 |=> ##1 !ctrl_reg.stop)
		else $error("stop request not cleared");
	a_hold_bus:
	assert property (state_reg == twm_pkg::TWM_HOLD && flag_reg &&
		code_reg != `TWM_ST_ARB |-> scl_oe_reg && $stable(shift_reg))
		else $error("bus not held while flag set");
	a_irq_level:
	assert property (flag_reg && ctrl_reg.ie |=> irq_reg)
		else $error("interrupt missing while flag set");

endmodule
`default_nettype wire
